// ### hw/adcp_regs.vh
// register layout, bus constants and timing counts of the amplifier control port
// assumes a 40 MHz system clock; included by the design files by bare name
`ifndef ADCP_REGS_VH
`define ADCP_REGS_VH

// bus address and direction
`define ADCP_DEV_ADDR        7'h6C
`define ADCP_RW_BIT          0
`define ADCP_WR_BYTES        2
`define ADCP_RD_BYTES        4
`define ADCP_BYTE_BITS       8

// first control byte fields
`define ADCP_C1_DIAG_EN      6
`define ADCP_C1_OFFS_EN      5
`define ADCP_C1_GAIN_FRONT   4
`define ADCP_C1_GAIN_REAR    3
`define ADCP_C1_UNMUTE_FRONT 2
`define ADCP_C1_UNMUTE_REAR  1
`define ADCP_C1_CLIP_SEL     0
`define ADCP_C1_WMASK        8'h7F

// second control byte fields
`define ADCP_C2_FAST_MUTE    5
`define ADCP_C2_STBY_OFF     4
`define ADCP_C2_LINE_DIAG    3
`define ADCP_C2_CUR_DET      2
`define ADCP_C2_HE_RIGHT     1
`define ADCP_C2_HE_LEFT      0
`define ADCP_C2_WMASK        8'h3F

// reset values
`define ADCP_CTRL_RST        8'h00

// status byte fields
`define ADCP_S_THERM         7
`define ADCP_S_DONE          6
`define ADCP_S3_STBY         7
`define ADCP_S3_DIAG         6

// mute timing
`define ADCP_CLK_KHZ         40000
`define ADCP_FAST_MUTE_US    1500
`define ADCP_NORM_MUTE_US    20000
`define ADCP_FAST_MUTE_CYC   ((`ADCP_FAST_MUTE_US * `ADCP_CLK_KHZ) / 1000)
`define ADCP_NORM_MUTE_CYC   ((`ADCP_NORM_MUTE_US * `ADCP_CLK_KHZ) / 1000)

`endif

// ### hw/adcp_diag_cycle.v
// one diagnostic measurement window for a set of fault inputs
// assumes fault inputs already synchronised to clk; restart is a one-cycle pulse
`timescale 1ns/10ps
`include "adcp_regs.vh"

module adcp_diag_cycle #(
  parameter WIDTH = 24
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // control
  input  wire             enable,
  input  wire             restart,
  // faults
  input  wire [WIDTH-1:0] fault_in,
  // results of the last finished window
  output reg  [WIDTH-1:0] result_reg,
  output reg              done_reg
);

  reg [WIDTH-1:0] persist_reg;
  reg             active_reg;

  always @(posedge clk) begin
    if (sys_rst) begin
      persist_reg <= {WIDTH{1'b1}};
      result_reg  <= {WIDTH{1'b0}};
      done_reg    <= 1'b0;
      active_reg  <= 1'b0;
    end else if (restart) begin
      // results latch from the window just ended, then a new window opens while enable is high
      result_reg  <= active_reg ? (persist_reg & fault_in) : {WIDTH{1'b0}};
      done_reg    <= active_reg;
      persist_reg <= {WIDTH{1'b1}};
      active_reg  <= enable;
    end else if (active_reg) begin
      // a fault drops out of the window the first cycle it is absent
      persist_reg <= persist_reg & fault_in;
      if (!enable) begin
        active_reg <= 1'b0;
      end
    end else if (enable) begin
      active_reg  <= 1'b1;
      persist_reg <= {WIDTH{1'b1}};
    end
  end

endmodule // adcp_diag_cycle

// ### hw/adcp_port.v
// two-wire slave port of a four-channel amplifier: control bytes in, status bytes out
// assumes bus lines resolved outside from the *_oe_n enables; scl sampled on clk
//
// Notes on behaviour
// - fault reported only if present whole window
// - every read restarts cycles, returns previous results
// - fast mute bit gives mute under 1.5 ms
// - data changes only while clock low
// - start and stop detected while clock high
// - eight bits msb first plus ack
// - receiver pulls ack low, transmitter releases
// - address bit 0 selects write or read
// - control one: diag and offset enables
// - control one: gain, unmute, clip threshold
// - control two: mute speed, standby, modes
// - read returns four status bytes in order
// - status one: thermal warning, cycle done
// - status one: current detect, diag kind
// - status one: short, open, supply, ground
// - three thermal warnings exposed to host
// - status three mirrors standby and diag enable
`timescale 1ns/10ps
`include "adcp_regs.vh"

module adcp_port #(
  parameter FAST_MUTE_CYC = `ADCP_FAST_MUTE_CYC,
  parameter NORM_MUTE_CYC = `ADCP_NORM_MUTE_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // two-wire bus
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n,
  // analog side fault inputs, per channel [fl, rl, fr, rr] x [cur, short, open, vcc, gnd]
  input  wire [19:0] chan_fault,
  input  wire [3:0]  chan_permanent,
  input  wire [2:0]  therm_warn,
  // amplifier controls
  output wire        diag_enable,
  output wire        offset_enable,
  output wire        gain_front_16db,
  output wire        gain_rear_16db,
  output wire        clip_threshold_select,
  output reg         mute_front_reg,
  output reg         mute_rear_reg,
  output wire        standby_off,
  output wire        line_diag_mode,
  output wire        current_detect_en,
  output wire        high_eff_right,
  output wire        high_eff_left
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_WR   = 5'b00100;
  localparam ST_RD   = 5'b01000;
  localparam ST_ACK  = 5'b10000;

  reg  [7:0]  amp_control_first_reg;
  reg  [7:0]  amp_control_second_reg;
  reg  [1:0]  scl_sync_reg;
  reg  [1:0]  sda_sync_reg;
  reg         scl_d_reg;
  reg         sda_d_reg;
  reg  [4:0]  state_reg;
  reg  [4:0]  ret_state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [2:0]  byte_cnt_reg;
  reg  [7:0]  shift_reg;
  reg         drive_low_reg;
  reg         read_seen_reg;
  reg         restart_reg;
  reg  [23:0] mute_cnt_reg;
  reg         mute_tgt_front_reg;
  reg         mute_tgt_rear_reg;

  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_cond;
  wire        stop_cond;
  wire [26:0] diag_result;
  wire        diag_done;
  wire [26:0] diag_in;
  wire [7:0]  status_byte;
  wire [7:0]  status_next;
  wire [23:0] mute_len;

  // returns status byte by index from latched results
  function [7:0] status_sel;
    input [2:0]  idx;
    input [26:0] res;
    input        done;
    input [7:0]  c1;
    input [7:0]  c2;
    begin
      case (idx)
        3'd0:    status_sel = {res[20], done, res[4], res[23], res[3:0]};
        3'd1:    status_sel = {c1[`ADCP_C1_OFFS_EN], 1'b0, res[9], res[24], res[8:5]};
        3'd2:    status_sel = {c2[`ADCP_C2_STBY_OFF], c1[`ADCP_C1_DIAG_EN],
                               res[14], res[25], res[13:10]};
        3'd3:    status_sel = {res[21], res[22], res[19], res[26], res[18:15]};
        default: status_sel = 8'hFF;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg              <= ST_IDLE;
      ret_state_reg          <= ST_IDLE;
      bit_cnt_reg            <= 4'h0;
      byte_cnt_reg           <= 3'h0;
      shift_reg              <= 8'h00;
      drive_low_reg          <= 1'b0;
      read_seen_reg          <= 1'b0;
      restart_reg            <= 1'b0;
      amp_control_first_reg  <= `ADCP_CTRL_RST;
      amp_control_second_reg <= `ADCP_CTRL_RST;
    end else begin
      restart_reg <= 1'b0;
      if (start_cond) begin
        // a pending read ends at a repeated start as at a stop
        restart_reg   <= read_seen_reg;
        read_seen_reg <= 1'b0;
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 4'h0;
        byte_cnt_reg  <= 3'h0;
        drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
        restart_reg   <= read_seen_reg;
        read_seen_reg <= 1'b0;
        state_reg     <= ST_IDLE;
        drive_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            drive_low_reg <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'd8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `ADCP_DEV_ADDR) begin
                  drive_low_reg <= 1'b1;
                  state_reg     <= ST_ACK;
                  ret_state_reg <= shift_reg[`ADCP_RW_BIT] ? ST_RD : ST_WR;
                  read_seen_reg <= shift_reg[`ADCP_RW_BIT];
                  byte_cnt_reg  <= 3'h0;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (byte_cnt_reg < `ADCP_WR_BYTES) begin
                // bits written as zero stay zero whatever the host sends
                if (byte_cnt_reg == 3'd0) begin
                  amp_control_first_reg <= shift_reg & `ADCP_C1_WMASK;
                end else begin
                  amp_control_second_reg <= shift_reg & `ADCP_C2_WMASK;
                end
                byte_cnt_reg  <= byte_cnt_reg + 3'h1;
                drive_low_reg <= 1'b1;
                state_reg     <= ST_ACK;
                ret_state_reg <= ST_WR;
              end else begin
                // extra bytes are not acknowledged
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // on the falling edge closing the ack clock, release the line, or for a read drive the first status bit
            if (scl_fall) begin
              if (ret_state_reg == ST_RD) begin
                shift_reg     <= status_byte;
                drive_low_reg <= ~status_byte[7];
                bit_cnt_reg   <= 4'h1;
              end else begin
                drive_low_reg <= 1'b0;
                bit_cnt_reg   <= 4'h0;
              end
              state_reg <= ret_state_reg;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'd8) begin
                drive_low_reg <= 1'b0;
                bit_cnt_reg   <= 4'd9;
              end else if (bit_cnt_reg == 4'd9) begin
                // host nack or last byte ends the transfer
                if (byte_cnt_reg == `ADCP_RD_BYTES - 1) begin
                  state_reg <= ST_IDLE;
                end else begin
                  byte_cnt_reg  <= byte_cnt_reg + 3'h1;
                  shift_reg     <= status_next;
                  drive_low_reg <= ~status_next[7];
                  bit_cnt_reg   <= 4'h1;
                end
              end else begin
                shift_reg     <= {shift_reg[6:0], 1'b0};
                drive_low_reg <= ~shift_reg[6];
                bit_cnt_reg   <= bit_cnt_reg + 4'h1;
              end
            end else if (scl_rise && bit_cnt_reg == 4'd9 && sda_s) begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low_reg;
  assign status_byte = status_sel(3'd0, diag_result, diag_done,
                                  amp_control_first_reg, amp_control_second_reg);
  assign status_next = status_sel(byte_cnt_reg + 3'h1, diag_result, diag_done,
                                  amp_control_first_reg, amp_control_second_reg);

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic windows

  // bit map: fl[4:0], rl[9:5], fr[14:10], rr[19:15], therm 20..22, perm fl..rr 23..26
  // thermal warnings and diag kind also pass the window filter
  assign diag_in = {chan_permanent, therm_warn, chan_fault};

  adcp_diag_cycle #(
    .WIDTH (27)
  ) u_diag (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .enable     (amp_control_first_reg[`ADCP_C1_DIAG_EN]),
    .restart    (restart_reg),
    .fault_in   (diag_in),
    .result_reg (diag_result),
    .done_reg   (diag_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control outputs and mute timing

  assign diag_enable           = amp_control_first_reg[`ADCP_C1_DIAG_EN];
  assign offset_enable         = amp_control_first_reg[`ADCP_C1_OFFS_EN];
  assign gain_front_16db       = amp_control_first_reg[`ADCP_C1_GAIN_FRONT];
  assign gain_rear_16db        = amp_control_first_reg[`ADCP_C1_GAIN_REAR];
  assign clip_threshold_select = amp_control_first_reg[`ADCP_C1_CLIP_SEL];
  assign standby_off           = amp_control_second_reg[`ADCP_C2_STBY_OFF];
  assign line_diag_mode        = amp_control_second_reg[`ADCP_C2_LINE_DIAG];
  assign current_detect_en     = amp_control_second_reg[`ADCP_C2_CUR_DET];
  assign high_eff_right        = amp_control_second_reg[`ADCP_C2_HE_RIGHT];
  assign high_eff_left         = amp_control_second_reg[`ADCP_C2_HE_LEFT];

  // the mute ramp is only a delay here; the analog ramp follows the mute outputs
  assign mute_len = amp_control_second_reg[`ADCP_C2_FAST_MUTE] ?
                    FAST_MUTE_CYC[23:0] - 24'h000001 :
                    NORM_MUTE_CYC[23:0] - 24'h000001;

  always @(posedge clk) begin
    if (sys_rst) begin
      mute_front_reg     <= 1'b1;
      mute_rear_reg      <= 1'b1;
      mute_tgt_front_reg <= 1'b1;
      mute_tgt_rear_reg  <= 1'b1;
      mute_cnt_reg       <= 24'h000000;
    end else begin
      mute_tgt_front_reg <= ~amp_control_first_reg[`ADCP_C1_UNMUTE_FRONT];
      mute_tgt_rear_reg  <= ~amp_control_first_reg[`ADCP_C1_UNMUTE_REAR];
      // unmute takes effect at once, muting completes after the selected time
      if (!mute_tgt_front_reg) begin
        mute_front_reg <= 1'b0;
      end
      if (!mute_tgt_rear_reg) begin
        mute_rear_reg <= 1'b0;
      end
      if ((mute_tgt_front_reg & ~mute_front_reg) | (mute_tgt_rear_reg & ~mute_rear_reg)) begin
        if (mute_cnt_reg >= mute_len) begin
          mute_cnt_reg   <= 24'h000000;
          mute_front_reg <= mute_tgt_front_reg;
          mute_rear_reg  <= mute_tgt_rear_reg;
        end else begin
          mute_cnt_reg <= mute_cnt_reg + 24'h000001;
        end
      end else begin
        mute_cnt_reg <= 24'h000000;
      end
    end
  end

endmodule // adcp_port

// ### sim/adcp_host.sv
// bus master model standing in for the host processor on the two-wire port
// assumes the bench resolves the data line with a pull-up from all drive enables
`timescale 1ns/10ps
module adcp_host (
  // bus lines, open drain on data
  output logic scl,
  output logic sda_oe_n,
  input  wire  sda
);
  localparam int QTR = 50;  // a quarter of the 200 ns bus clock

  initial begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end

  // the clock stands high between frames
  task automatic bus_start();
    #QTR;
    sda_oe_n = 1'b0;
    #(2 * QTR);
    scl = 1'b0;
  endtask

  // long low phase first: the port lets go of the ack only a few cycles after the fall
  task automatic bus_stop();
    #(2 * QTR);
    sda_oe_n = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_oe_n = 1'b1;
    #(2 * QTR);
  endtask

  // data changes mid low phase and is sampled late in the high phase
  task automatic bus_bit(input logic tx, output logic rx);
    #QTR;
    sda_oe_n = tx;
    #QTR;
    scl = 1'b1;
    #(2 * QTR - 5);
    rx = sda;
    #5;
    scl = 1'b0;
  endtask

  // a one releases the line, so reads send all ones
  task automatic bus_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--)
      bus_bit(tx[i], rx[i]);
    bus_bit(ack_in, ack);
  endtask
endmodule  // adcp_host

// ### sim/adcp_port_sva.sv
// pin-level assertions for the amplifier control port
// assumes scl_in and sda_in carry the resolved bus levels
`timescale 1ns/10ps
module adcp_port_sva #(
  parameter FAST_MUTE_CYC = 60000,
  parameter NORM_MUTE_CYC = 800000
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // bus
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  // controls
  input wire diag_enable,
  input wire standby_off,
  input wire mute_front_reg,
  input wire mute_rear_reg
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic [3:0]  hi_reg;     // consecutive samples with the clock high
  logic [7:0]  drv_reg;    // cycles the data line has been driven
  logic [31:0] quiet_reg;  // cycles since the port last drove
  wire  [3:0]  ctl = {diag_enable, standby_off, mute_front_reg, mute_rear_reg};

  always @(posedge clk) begin
    hi_reg    <= (!scl_in || sys_rst) ? 4'h0 : ((hi_reg == 4'hF) ? hi_reg : hi_reg + 4'h1);
    drv_reg   <= (sda_oe_n || sys_rst) ? 8'h00 : ((drv_reg == 8'hFF) ? drv_reg : drv_reg + 8'h01);
    quiet_reg <= (!sda_oe_n || sys_rst) ? 32'h0 : quiet_reg + 32'h1;
  end

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  chk_rst_ctrl: assert property (disable iff (1'b0) sys_rst |=> ctl == 4'b0011)
    else $error("controls not at reset value");
  chk_rst_release: assert property (disable iff (1'b0) sys_rst |=> sda_oe_n)
    else $error("data line driven in reset");
  chk_open_drain: assert property (!sda_oe_n |-> !sda_out)
    else $error("driven data not low");
  chk_hold_high: assert property (scl_in && hi_reg >= 4'h3 |-> $stable(sda_oe_n))
    else $error("data changed with clock high");
  chk_start_quiet: assert property (s_start |=> sda_oe_n [*8])
    else $error("drive right after start");
  chk_stop_release: assert property (s_stop |=> sda_oe_n [*6])
    else $error("drive right after stop");
  chk_drive_len: assert property (drv_reg <= 8'd90)
    else $error("data held low past a byte");
  // mute timers may run on after the last ack, hence the allowance
  chk_ctl_after_ack: assert property ($changed(ctl) |-> quiet_reg < NORM_MUTE_CYC + 2000)
    else $error("control moved without a write");
endmodule  // adcp_port_sva

////////////////////////////////////////////////////////////////////////////////
bind adcp_port adcp_port_sva #(.FAST_MUTE_CYC(FAST_MUTE_CYC), .NORM_MUTE_CYC(NORM_MUTE_CYC))
  u_sva (.clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
         .diag_enable, .standby_off, .mute_front_reg, .mute_rear_reg);

// ### sim/tb.sv
// self-checking bench of the amplifier control port
// assumes the host model drives the bus; sda is resolved here with a pull-up
`timescale 1ns/10ps
`include "adcp_regs.vh"
module tb;
  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [11:0] outs;
  } adcp_row_t;
  logic        clk;
  logic        sys_rst;
  logic [19:0] chan_fault;
  logic [3:0]  chan_permanent;
  logic [2:0]  therm_warn;
  logic [31:0] rdat;
  logic [7:0]  junk;
  logic [2:0]  acks;
  logic        ak;
  int          bad_count;
  int          n_checks;
  wire         scl;
  wire         host_oe_n;
  wire         sda_out;
  wire         sda_oe_n;
  wire  [11:0] ctrl;
  wire         sda = host_oe_n & (sda_oe_n | sda_out);
  adcp_row_t   rows [6] = '{{8'h40, 8'h10, 12'h870}, {8'h3F, 8'h1F, 12'h79F},
    {8'hFF, 8'hDF, 12'hF9F}, {8'h04, 8'h12, 12'h032}, {8'h02, 8'h11, 12'h051},
    {8'h00, 8'h00, 12'h060}};

  // short mute counts keep the run brief
  adcp_port #(.FAST_MUTE_CYC(20), .NORM_MUTE_CYC(400)) DUT (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chan_fault(chan_fault), .chan_permanent(chan_permanent),
    .therm_warn(therm_warn), .diag_enable(ctrl[11]), .offset_enable(ctrl[10]),
    .gain_front_16db(ctrl[9]), .gain_rear_16db(ctrl[8]), .clip_threshold_select(ctrl[7]),
    .mute_front_reg(ctrl[6]), .mute_rear_reg(ctrl[5]), .standby_off(ctrl[4]),
    .line_diag_mode(ctrl[3]), .current_detect_en(ctrl[2]), .high_eff_right(ctrl[1]),
    .high_eff_left(ctrl[0]));
  adcp_host host (.scl(scl), .sda_oe_n(host_oe_n), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // leaves the frame open so a caller may add bytes before the stop
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    host.bus_start();
    host.bus_byte({`ADCP_DEV_ADDR, 1'b0}, 1'b1, junk, acks[2]);
    host.bus_byte(a, 1'b1, junk, acks[1]);
    host.bus_byte(b, 1'b1, junk, acks[0]);
  endtask

  task automatic rd();
    logic a;
    host.bus_start();
    host.bus_byte({`ADCP_DEV_ADDR, 1'b1}, 1'b1, junk, ak);
    for (int i = 3; i >= 0; i--)
      host.bus_byte(8'hFF, i == 0, rdat[8*i +: 8], a);
    host.bus_stop();
  endtask

  task automatic setin(input logic [19:0] f, input logic [3:0] p);
    @(posedge clk);
    #2;
    chan_fault = f;
    chan_permanent = p;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    chan_fault = 20'h00000;
    chan_permanent = 4'h0;
    therm_warn = 3'h7;
    cyc(4);
    sys_rst = 1'b0;
    cyc(4);
    check("reset controls", {20'h0, 12'h060}, ctrl);
    foreach (rows[i]) begin
      wr(rows[i].c1, rows[i].c2);
      host.bus_stop();
      check("write acks", 32'h0, acks);
      cyc(500);
      check("controls", rows[i].outs, ctrl);
    end
    host.bus_start();
    host.bus_byte({`ADCP_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, junk, ak);
    host.bus_stop();
    check("foreign address ack", 32'h1, ak);
    wr(8'h06, 8'h10);
    host.bus_byte(8'h55, 1'b1, junk, ak);
    host.bus_stop();
    check("third byte ack", 32'h1, ak);
    cyc(500);
    wr(8'h00, 8'h30);
    host.bus_stop();
    cyc(100);
    check("fast mute", 32'h3, ctrl[6:5]);
    wr(8'h06, 8'h10);
    host.bus_stop();
    cyc(500);
    wr(8'h00, 8'h10);
    host.bus_stop();
    cyc(100);
    check("normal mute early", 32'h0, ctrl[6:5]);
    cyc(500);
    check("normal mute late", 32'h3, ctrl[6:5]);
    setin(20'h02008, 4'h0);
    wr(8'h40, 8'h10);
    host.bus_stop();
    cyc(200);
    rd();
    rd();
    rd();
    check("diag bytes", {8'hC8, 8'h00, 8'hC8, 8'hC0}, rdat);
    check("read address ack", 32'h0, ak);
    setin(20'h00000, 4'h0);
    rd();
    check("old result", 32'hC8, rdat[31:24]);
    rd();
    check("cleared result", 32'hC0, rdat[31:24]);
    cyc(100);
    setin(20'h00011, 4'hF);
    rd();
    rd();
    check("partial window", 32'hC0, rdat[31:24]);
    rd();
    check("full window", 32'hF1, rdat[31:24]);
    check("full window bytes", {8'hF1, 8'h10, 8'hD0, 8'hD0}, rdat);
    wr(8'h60, 8'h10);
    host.bus_stop();
    cyc(100);
    rd();
    check("offset status", 32'h90, rdat[23:16]);
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(4);
    check("reset again", 32'h060, ctrl);
    rd();
    check("reset status", 32'h0, rdat);
    test_done();
  end

  // the whole sequence needs well under half of this
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
endmodule  // tb
